/* File: rtl/flash_host.sv */
// Summary of operation
// - clock mode 0 or 3 only, chosen per command
// - host holds clock low in mode 0, high in mode 3 when idle
// - cycles run falling edge to falling edge; mode 0 starts at select
// - command opens with an instruction byte then optional fields
// - 1-1-1, 1-2-2 and 1-4-4 lane widths are supported
// - all-quad mode carries every field four bits at a time
// - select stays low for the whole command
// - continuous read leaves out the instruction byte
// - 24 or 32 bit address, one bit group per transfer edge
// - low bit of a group on lane 0, higher bits on higher lanes
// - mode bits follow the address at the address rate
// - host keeps the clock running through latency
// - no-data commands end on a whole number of bytes
// - most significant bit first, bytes in rising address order
// - host makes a select falling edge before the first command
`timescale 1ns/1ps
`default_nettype none

module flash_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic spi_mode3,
  input wire logic ddr,
  input wire logic [7:0] cmd_op,
  input wire logic has_instr,
  input wire flash_host_pkg::lane_width_t instr_width,
  input wire flash_host_pkg::lane_width_t addr_width,
  input wire flash_host_pkg::lane_width_t data_width,
  input wire logic has_addr,
  input wire logic addr4,
  input wire logic [31:0] addr,
  input wire logic has_mode,
  input wire logic [7:0] mode_bits,
  input wire logic [4:0] dummy_cycles,
  input wire flash_host_pkg::data_dir_t data_dir,
  input wire logic [15:0] data_len,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] io_in,
  output logic busy,
  output logic done,
  output logic wr_take,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_out,
  output logic [3:0] io_oe
);
  import flash_host_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [5:0] beats_of(input logic [5:0] bits,
                                          input lane_width_t w);
    beats_of = bits >> w;
  endfunction

  function automatic logic [5:0] lane_bits(input lane_width_t w);
    lane_bits = 6'h01 << w;
  endfunction

  // lanes 2 and 3 stay high outside quad groups
  function automatic logic [3:0] drive_of(input logic [31:0] s,
                                          input lane_width_t w);
    case (w)
      LANE_4: drive_of = s[31:28];
      LANE_2: drive_of = {2'b11, s[31:30]};
      default: drive_of = {2'b11, 1'b0, s[31]};
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input lane_width_t w,
                                       input logic drive);
    if (drive) begin
      oe_of = (w == LANE_1) ? 4'hd : 4'hf;
    end else begin
      oe_of = (w == LANE_4) ? 4'h0 : 4'hc;
    end
  endfunction

  function automatic logic [7:0] take_in(input logic [7:0] r,
                                         input logic [3:0] io,
                                         input lane_width_t w);
    case (w)
      LANE_4: take_in = {r[3:0], io};
      LANE_2: take_in = {r[5:0], io[1:0]};
      default: take_in = {r[6:0], io[1]};
    endcase
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  logic [3:0] io_meta;
  logic [3:0] io_sync;
  logic c_mode3;
  logic c_ddr;
  logic [7:0] c_op;
  logic c_has_instr;
  lane_width_t c_iw;
  lane_width_t c_aw;
  lane_width_t c_dw;
  logic c_has_addr;
  logic c_a4;
  logic [31:0] c_addr;
  logic c_has_mode;
  logic [7:0] c_mode;
  logic [4:0] c_dummy;
  data_dir_t c_dir;
  phase_t phase;
  logic [1:0] q;
  logic [3:0] qcnt;
  logic [31:0] sh;
  logic [5:0] beats;
  logic [4:0] dcnt;
  logic [15:0] left;
  logic [7:0] rsh;
  logic [3:0] gcnt;

  // ***************************************************************
  // decode
  // ***************************************************************
  wire qevent = (qcnt == 4'(QTR_CYC - 1));
  wire [1:0] q_n = q + 2'h1;
  wire gap_done = (gcnt == 4'(CS_HIGH_CYC - 1));
  wire in_shift = (phase == PH_INSTR) || (phase == PH_ADDR) ||
                  (phase == PH_MODE) || (phase == PH_WRITE);
  wire cur_ddr = c_ddr && (phase != PH_INSTR);
  // single rate launches on falling edge
  wire lp_cur = cur_ddr ? q_n[0] : (q_n == Q_FALL);
  wire exhausted = qevent && ((phase == PH_SETUP) ||
                   (in_shift && beats == 6'h00 && lp_cur));

  phase_t data_step;
  phase_t after_mode;
  phase_t after_addr;
  phase_t after_instr;
  phase_t nxt;
  phase_t eff;
  assign data_step = (c_dir == DIR_WRITE) ? PH_WRITE :
                     (c_dir == DIR_READ) ?
                     ((c_dummy == 5'h00) ? PH_READ : PH_DUMMY) : PH_FINISH;
  // mode bits straight after the address
  assign after_mode = data_step;
  assign after_addr = c_has_mode ? PH_MODE : after_mode;
  assign after_instr = c_has_addr ? PH_ADDR : after_addr;

  always_comb begin
    case (phase)
      PH_SETUP: nxt = c_has_instr ? PH_INSTR : after_instr;
      PH_INSTR: nxt = after_instr;
      PH_ADDR: nxt = after_addr;
      PH_MODE: nxt = after_mode;
      PH_WRITE: nxt = (left != 16'h0000) ? PH_WRITE : PH_FINISH;
      default: nxt = PH_FINISH;
    endcase
  end
  assign eff = exhausted ? nxt : phase;

  lane_width_t eff_w;
  assign eff_w = (eff == PH_INSTR) ? c_iw :
                 (eff == PH_ADDR || eff == PH_MODE) ? c_aw : c_dw;

  // fields left aligned so the top bits leave first
  logic [31:0] ld_sh;
  logic [5:0] ld_beats;
  always_comb begin
    case (nxt)
      PH_INSTR: ld_sh = {c_op, 24'h000000};
      PH_ADDR: ld_sh = c_a4 ? c_addr : {c_addr[23:0], 8'h00};
      PH_MODE: ld_sh = {c_mode, 24'h000000};
      default: ld_sh = {wr_data, 24'h000000};
    endcase
    case (nxt)
      PH_INSTR: ld_beats = beats_of(INSTR_BITS, c_iw);
      PH_ADDR: ld_beats = beats_of(c_a4 ? ADDR4_BITS : ADDR3_BITS, c_aw);
      PH_MODE: ld_beats = beats_of(BYTE_BITS, c_aw);
      default: ld_beats = beats_of(BYTE_BITS, c_dw);
    endcase
  end

  wire [31:0] eff_sh = exhausted ? ld_sh : sh;
  wire [5:0] eff_beats = exhausted ? ld_beats : beats;
  wire eff_shift = (eff == PH_INSTR) || (eff == PH_ADDR) ||
                   (eff == PH_MODE) || (eff == PH_WRITE);
  // first double rate group waits for the low quarter
  wire lp_eff = (c_ddr && eff != PH_INSTR) ? q_n[0] : (q_n == Q_FALL);
  wire launch = qevent && eff_shift && lp_eff && eff_beats != 6'h00;
  wire load_wr = exhausted && nxt == PH_WRITE;
  // read data taken on rising edges, or every edge
  wire read_edge = qevent && phase == PH_READ &&
                   (q_n == Q_RISE || (c_ddr && q_n == Q_FALL));
  wire rbyte_done = read_edge && beats == 6'h01;
  // a double rate frame may end at the low quarter; select then rises at
  // the next event instead of letting one more rising edge out
  wire cs_end = qevent && phase == PH_FINISH &&
                (q_n == Q_LOW_LATE || q == Q_LOW_LATE);
  wire [7:0] r_next = take_in(rsh, io_sync, c_dw);

  // ***************************************************************
  // input synchroniser
  // ***************************************************************
  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_meta <= 4'h0;
      io_sync <= 4'h0;
    end else begin
      io_meta <= io_in;
      io_sync <= io_meta;
    end
  end

  // ***************************************************************
  // command capture
  // ***************************************************************
  // a start is only taken while idle; data lengths of zero mean none
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_mode3 <= 1'b0;
      c_ddr <= 1'b0;
      c_op <= 8'h00;
      c_has_instr <= 1'b0;
      c_iw <= LANE_1;
      c_aw <= LANE_1;
      c_dw <= LANE_1;
      c_has_addr <= 1'b0;
      c_a4 <= 1'b0;
      c_addr <= 32'h00000000;
      c_has_mode <= 1'b0;
      c_mode <= 8'h00;
      c_dummy <= 5'h00;
      c_dir <= DIR_NONE;
    end else if (phase == PH_IDLE && start) begin
      // mode 0 or 3 chosen per command
      c_mode3 <= spi_mode3;
      c_ddr <= ddr;
      c_op <= cmd_op;
      c_has_instr <= has_instr;
      c_iw <= instr_width;
      c_aw <= addr_width;
      c_dw <= data_width;
      c_has_addr <= has_addr;
      c_a4 <= addr4;
      c_addr <= addr;
      c_has_mode <= has_mode;
      c_mode <= mode_bits;
      c_dummy <= dummy_cycles;
      c_dir <= (data_len == 16'h0000) ? DIR_NONE : data_dir;
    end
  end

  // ***************************************************************
  // quarter timer
  // ***************************************************************
  // clock keeps running through latency
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt <= 4'h0;
      q <= 2'h1;
    end else if (phase == PH_IDLE || phase == PH_GAP) begin
      qcnt <= 4'h0;
      q <= 2'h1;
    end else begin
      qcnt <= qevent ? 4'h0 : qcnt + 4'h1;
      q <= qevent ? q_n : q;
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      sh <= 32'h00000000;
      beats <= 6'h00;
      dcnt <= 5'h00;
      left <= 16'h0000;
      gcnt <= 4'h0;
    end else begin
      case (phase)
        PH_IDLE: begin
          gcnt <= 4'h0;
          left <= data_len;
          if (start) begin
            phase <= PH_SETUP;
          end
        end
        PH_DUMMY: begin
          if (qevent && q_n == Q_FALL) begin
            if (dcnt == 5'h01) begin
              phase <= PH_READ;
              beats <= beats_of(BYTE_BITS, c_dw);
            end else begin
              dcnt <= dcnt - 5'h01;
            end
          end
        end
        PH_READ: begin
          if (read_edge) begin
            if (beats == 6'h01) begin
              beats <= beats_of(BYTE_BITS, c_dw);
              left <= left - 16'h0001;
              // read ends only by raising select
              if (left == 16'h0001) begin
                phase <= PH_FINISH;
              end
            end else begin
              beats <= beats - 6'h01;
            end
          end
        end
        // select rises after the last whole byte
        PH_FINISH: begin
          if (cs_end) begin
            phase <= PH_GAP;
          end
        end
        PH_GAP: begin
          gcnt <= gcnt + 4'h1;
          if (gap_done) begin
            phase <= PH_IDLE;
          end
        end
        default: begin
          if (qevent) begin
            phase <= eff;
            sh <= launch ? eff_sh << lane_bits(eff_w) : eff_sh;
            beats <= launch ? eff_beats - 6'h01 : eff_beats;
          end
          if (exhausted) begin
            dcnt <= c_dummy;
          end
          if (load_wr) begin
            left <= left - 16'h0001;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // pins
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n <= 1'b1;
      sck <= 1'b0;
      io_out <= IO_IDLE_OUT;
      io_oe <= IO_IDLE_OE;
    end else begin
      // select low from start to finish
      // select falls two cycles after start
      // the clock takes its idle level first, so a mode change never
      // makes a clock edge while the device is selected
      if (phase == PH_SETUP) begin
        cs_n <= 1'b0;
      end else if (cs_end) begin
        cs_n <= 1'b1;
      end
      // idle clock level follows the mode
      if (phase == PH_IDLE) begin
        sck <= start ? spi_mode3 : c_mode3;
      end else if (phase == PH_GAP) begin
        sck <= c_mode3;
      end else if (qevent && !cs_end) begin
        sck <= (q_n < 2'h2);
      end
      // low bit of each group on lane 0
      if (launch) begin
        io_out <= drive_of(eff_sh, eff_w);
        io_oe <= oe_of(eff_w, 1'b1);
      end else if (exhausted && (eff == PH_DUMMY || eff == PH_READ)) begin
        io_out <= IO_IDLE_OUT;
        io_oe <= oe_of(c_dw, 1'b0);
      end else if (phase == PH_GAP) begin
        // reset lane driven high one cycle after select rises
        io_out <= IO_IDLE_OUT;
        io_oe <= IO_IDLE_OE;
      end
    end
  end

  // ***************************************************************
  // user side
  // ***************************************************************
  // write bytes are consumed one at a time, no buffer is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      rsh <= 8'h00;
    end else begin
      busy <= (phase == PH_IDLE) ? start : !(phase == PH_GAP && gap_done);
      done <= phase == PH_GAP && gap_done;
      wr_take <= load_wr;
      rd_valid <= rbyte_done;
      if (read_edge) begin
        rsh <= r_next;
      end
      // first byte read is the lowest address
      if (rbyte_done) begin
        rd_data <= r_next;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/flash_host_pkg.sv */
package flash_host_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 80;
  // one serial clock period is split into four equal quarters
  localparam int QTR_CYC = SCK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int CS_HIGH_NS = 50;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;

  // ***************************************************************
  // quarters of a serial clock period
  // ***************************************************************
  localparam logic [1:0] Q_RISE = 2'h0;
  localparam logic [1:0] Q_FALL = 2'h2;
  localparam logic [1:0] Q_LOW_LATE = 2'h3;

  // ***************************************************************
  // field sizes in bits
  // ***************************************************************
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;

  // ***************************************************************
  // pin levels
  // ***************************************************************
  // write protect and reset lanes held high while not in use
  localparam logic [3:0] IO_IDLE_OUT = 4'hc;
  localparam logic [3:0] IO_IDLE_OE = 4'hc;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b10
  } lane_width_t;

  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_WRITE = 2'b01,
    DIR_READ = 2'b10
  } data_dir_t;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0000,
    PH_SETUP = 4'b0001,
    PH_INSTR = 4'b0010,
    PH_ADDR = 4'b0011,
    PH_MODE = 4'b0100,
    PH_WRITE = 4'b0101,
    PH_DUMMY = 4'b0110,
    PH_READ = 4'b0111,
    PH_FINISH = 4'b1000,
    PH_GAP = 4'b1001
  } phase_t;

endpackage

/* File: test/flash_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_host_properties import flash_host_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic spi_mode3,
  input wire logic ddr,
  input wire logic busy,
  input wire logic done,
  input wire logic wr_take,
  input wire logic rd_valid,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic last_m;

  // clock mode of the latest command; the idle level must follow it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_m <= 1'b0;
    end else if (start && !busy) begin
      last_m <= spi_mode3;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ********
  // properties
  // ********
  property p_idle_level;
    !busy |-> sck == last_m;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock not at its idle level");

  property p_cs_fall_level;
    $fell(cs_n) |-> sck == last_m;
  endproperty
  a_cs_fall_level: assert property (p_cs_fall_level)
    else $error("clock level wrong at select fall");

  property p_start_sel;
    start && !busy |=> busy && cs_n ##1 busy && !cs_n;
  endproperty
  a_start_sel: assert property (p_start_sel)
    else $error("select did not fall after start");

  property p_one_select;
    $fell(cs_n) |-> $past(busy) && !$past(busy, 2);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("select fell inside a command");

  property p_cs_gap;
    $rose(cs_n) |-> cs_n[*5];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high gap too short");

  property p_high_phase;
    $rose(sck) && !cs_n |-> sck[*4] ##1 !sck;
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("clock high phase not four cycles");

  property p_low_phase;
    $fell(sck) |-> !sck[*2];
  endproperty
  a_low_phase: assert property (p_low_phase)
    else $error("clock low phase too short");

  property p_done_end;
    $fell(busy) |-> done ##1 !done;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy fell without a single done pulse");

  property p_idle_lanes;
    cs_n && !busy |-> io_oe == IO_IDLE_OE && io_out[3:2] == 2'b11;
  endproperty
  a_idle_lanes: assert property (p_idle_lanes)
    else $error("idle lanes not held high");

  property p_data_in_cmd;
    wr_take || rd_valid |-> busy && !cs_n;
  endproperty
  a_data_in_cmd: assert property (p_data_in_cmd)
    else $error("data handshake outside a command");

  c_mode3: cover property (start && !busy && spi_mode3);
  c_ddr: cover property (start && !busy && ddr);
  c_read: cover property (rd_valid);
endmodule

bind flash_host flash_host_properties chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .start(start),
  .spi_mode3(spi_mode3), .ddr(ddr), .busy(busy), .done(done),
  .wr_take(wr_take), .rd_valid(rd_valid), .sck(sck), .cs_n(cs_n),
  .io_out(io_out), .io_oe(io_oe)
);

`default_nettype wire

/* File: test/flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input var int pre,
  input var int dl,
  output logic [3:0] dout,
  output logic [3:0] doe
);
  logic [3:0] rx [0:255];
  logic [7:0] b;
  logic [3:0] v;
  int cnt;
  int g;
  int n;

  // outputs float until a read is due
  initial begin
    dout = 4'h0;
    doe = 4'h0;
    cnt = 0;
    g = 0;
  end

  always @(negedge cs_n) begin
    cnt = 0;
    g = 0;
  end

  // groups taken on rising edges only
  always @(posedge sck) begin
    if (!cs_n) begin
      rx[cnt[7:0]] = io;
      cnt++;
    end
  end

  // read data after latency
  // keeps streaming past the last byte, so the host must stop it
  always @(negedge sck) begin
    if (!cs_n && dl != 0 && cnt >= pre) begin
      n = 8 / dl;
      b = 8'(8'hc3 + 8'h11 * (g / n));
      v = 4'((b >> (8 - dl * (g % n + 1))) & ((1 << dl) - 1));
      dout = dl == 1 ? {2'b00, v[0], 1'b0} : v;
      doe = dl == 1 ? 4'h2 : dl == 2 ? 4'h3 : 4'hf;
      g++;
    end
  end

  always @(posedge cs_n) doe = 4'h0;
endmodule

`default_nettype wire

/* File: test/multi_io_serial_flash_command_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module multi_io_serial_flash_command_port_tb;
  import flash_host_pkg::*;
  typedef struct {
    logic [5:0] f;
    lane_width_t iw, aw, dw;
    logic [7:0] op;
    logic [31:0] ad;
    logic [7:0] mb;
    logic [4:0] dc;
    data_dir_t dir;
    logic [15:0] len;
    int rises;
  } row_t;
  logic ref_clk, rst_n, start, spi_mode3, ddr, has_instr, has_addr;
  logic addr4, has_mode, busy, done, wr_take, rd_valid, sck, cs_n;
  logic [7:0] cmd_op, mode_bits, wr_data, rd_data;
  lane_width_t instr_width, addr_width, data_width;
  logic [31:0] addr;
  logic [4:0] dummy_cycles;
  data_dir_t data_dir;
  logic [15:0] data_len;
  logic [3:0] io_in, io_out, io_oe, dout, doe;
  logic [3:0] ev[$], em[$];
  logic [7:0] rd_q[$];
  int num_errors, tests_run, cyc, widx, pre, dl;
  row_t rows[8];

  flash_host dut (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
    .spi_mode3(spi_mode3), .ddr(ddr), .cmd_op(cmd_op),
    .has_instr(has_instr), .instr_width(instr_width),
    .addr_width(addr_width), .data_width(data_width),
    .has_addr(has_addr), .addr4(addr4), .addr(addr),
    .has_mode(has_mode), .mode_bits(mode_bits),
    .dummy_cycles(dummy_cycles), .data_dir(data_dir),
    .data_len(data_len), .wr_data(wr_data), .io_in(io_in),
    .busy(busy), .done(done), .wr_take(wr_take), .rd_valid(rd_valid),
    .rd_data(rd_data), .sck(sck), .cs_n(cs_n), .io_out(io_out),
    .io_oe(io_oe));
  flash_model fm (.sck(sck), .cs_n(cs_n), .io(io_in), .pre(pre),
    .dl(dl), .dout(dout), .doe(doe));

  // wire level: driver, else pull-up on lanes 2 and 3, else stale inverse
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : doe[i] ? dout[i] : i > 1 || !dout[i];
    end
  end

  function automatic int lw(input lane_width_t w);
    return w == LANE_4 ? 4 : w == LANE_2 ? 2 : 1;
  endfunction

  function automatic logic [7:0] wb(input int k);
    return 8'(8'h3c + 8'h25 * k);
  endfunction

  // one byte split into lane groups, high group first
  task automatic push(input logic [7:0] v, input int l);
    for (int i = 8 - l; i >= 0; i -= l) begin
      em.push_back(4'((1 << l) - 1));
      ev.push_back(4'(v >> i) & em[$]);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // x: 0 plain, 1 extra start while busy, 2 reset in mid command
  task automatic run(input row_t r, input int x);
    int n;
    int ig;
    int e;
    ev.delete();
    em.delete();
    rd_q.delete();
    widx = 0;
    if (r.f[3]) push(r.op, lw(r.iw));
    ig = ev.size();
    for (n = r.f[1] ? 3 : 2; n >= 0 && r.f[2]; n--) begin
      push(8'(r.ad >> 8 * n), lw(r.aw));
    end
    if (r.f[0]) push(r.mb, lw(r.aw));
    for (n = 0; n < r.len && r.dir == DIR_WRITE; n++) push(wb(n), lw(r.dw));
    dl = r.dir == DIR_READ ? lw(r.dw) : 0;
    pre = r.rises - r.len * 8 / lw(r.dw);
    @(posedge ref_clk);
    #1;
    {spi_mode3, ddr, has_instr, has_addr, addr4, has_mode} = r.f;
    {cmd_op, addr, mode_bits, dummy_cycles} = {r.op, r.ad, r.mb, r.dc};
    instr_width = r.iw;
    addr_width = r.aw;
    data_width = r.dw;
    data_dir = r.dir;
    {data_len, wr_data} = {r.len, wb(0)};
    start = 1'b1;
    for (n = 0; n < 3000 && done !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      start = x == 1 && n == 20;
      if (x == 2 && n == 60) break;
    end
    if (x == 2) begin
      rst_n = 1'b0;
      #1;
      `CHK("rst_pins", {1'b1, 1'b0, 1'b0}, {cs_n, sck, busy});
      repeat (2) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      return;
    end
    if (n == 3000) `CHK("done", 1'b1, done);
    `CHK("rises", r.rises, fm.cnt);
    for (n = 0; n < fm.cnt; n++) begin
      e = (r.f[4] && n >= ig) ? ig + 2 * (n - ig) : n;
      if (e < ev.size()) `CHK("group", ev[e], fm.rx[n] & em[e]);
    end
    if (r.dir == DIR_READ) begin
      `CHK("rd_n", r.len, 16'(rd_q.size()));
      foreach (rd_q[k]) `CHK("rd", 8'(8'hc3 + 8'h11 * k), rd_q[k]);
    end
    if (r.dir == DIR_WRITE) `CHK("wr_n", r.len, 16'(widx));
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("idle", {1'b1, r.f[5], 1'b0}, {cs_n, sck, busy});
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // read bytes are sampled before the write byte is advanced
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (wr_take === 1'b1) begin
      widx++;
      #1;
      wr_data = wb(widx);
    end
  end

  // hang guard, far above the few thousand cycles of the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  always @(posedge sck) `CHK("clash", 4'h0, io_oe & doe);

  initial begin
    {rst_n, start, spi_mode3, ddr, has_instr, has_addr} = 6'h00;
    {addr4, has_mode, cmd_op, mode_bits, wr_data, addr} = 58'h0;
    {dummy_cycles, data_len} = 21'h0;
    instr_width = LANE_1;
    addr_width = LANE_1;
    data_width = LANE_1;
    data_dir = DIR_NONE;
    {num_errors, tests_run, cyc, widx, pre, dl} = '0;
    // flags: mode3, ddr, instr, addr, addr32, mode bits
    rows = '{
      '{6'h08, LANE_1, LANE_1, LANE_1, 8'h06, 32'h0, 8'h0, 5'h0,
        DIR_NONE, 16'h0, 8},
      '{6'h26, LANE_1, LANE_1, LANE_1, 8'h02, 32'h00a55a01, 8'h0, 5'h0,
        DIR_WRITE, 16'h2, 48},
      '{6'h0e, LANE_1, LANE_4, LANE_4, 8'h34, 32'h81c3e7ff, 8'h0, 5'h0,
        DIR_WRITE, 16'h3, 22},
      '{6'h0d, LANE_1, LANE_2, LANE_2, 8'hbb, 32'h003c96f0, 8'ha0, 5'h4,
        DIR_READ, 16'h2, 36},
      '{6'h2d, LANE_4, LANE_4, LANE_4, 8'heb, 32'h00f00f5a, 8'h5f, 5'h2,
        DIR_READ, 16'h1, 14},
      '{6'h0e, LANE_1, LANE_1, LANE_1, 8'h13, 32'hc0ffee11, 8'h0, 5'h0,
        DIR_READ, 16'h1, 48},
      '{6'h05, LANE_1, LANE_4, LANE_4, 8'heb, 32'h00123456, 8'ha5, 5'h4,
        DIR_READ, 16'h2, 16},
      '{6'h3c, LANE_1, LANE_4, LANE_4, 8'h38, 32'h00abcdef, 8'h0, 5'h0,
        DIR_WRITE, 16'h2, 13}};
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK("rst", {IO_IDLE_OE, IO_IDLE_OUT}, {io_oe, io_out});
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i], 0);
    run(rows[0], 1);
    run(rows[3], 2);
    run(rows[0], 0);
    final_report();
  end
endmodule

`default_nettype wire
